// >>> design/llcc_top.sv
// Purpose: Digital control of a line locked pixel clock synthesizer.
// Assumes: hclk stands in for the oscillator; the pixel clock is an enable derived from it.
// Notes:   Registers reachable over AHB-Lite and the two-wire slave; AHB wins a same cycle clash.
`timescale 1ns/100ps
`include "llcc_map.svh"
module llcc_top
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Video and supply pins
    input  wire logic        hsync_in,
    input  wire logic        vsync_in,
    input  wire logic        ext_feedback_in,
    input  wire logic        supply_low,
    // Serial bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        slave_addr_select,
    output logic             sda_out,
    output logic             sda_oe,
    // Clock and loop outputs
    output logic             pix_clk_out,
    output logic             hsync_out,
    output logic             vsync_out,
    output logic             lock_out,
    output logic             pump_up,
    output logic             pump_dn,
    output logic             irq
);
    // ********************************
    // Pin synchronisers
    // ********************************
    logic [6:0] pin_s;
    logic       hs_s, vs_s, ef_s, uv_s, scl_s, sda_s, asel_s;
    assign {asel_s, sda_s, scl_s, uv_s, ef_s, vs_s, hs_s} = pin_s;
    llcc_sync2 #(.W(7)) u_sync
    (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({slave_addr_select, sda_in, scl_in, supply_low, ext_feedback_in, vsync_in, hsync_in}),
        .q     (pin_s)
    );

    // ********************************
    // Serial slave
    // ********************************
    llcc_pkg::llcc_core_t st, nx;
    logic [7:0] i2c_rd;
    logic [3:0] i2c_ridx, i2c_widx;
    logic [7:0] i2c_wd;
    logic       i2c_wr;
    assign sda_out = 1'b0;
    llcc_i2c u_i2c
    (
        .clk      (hclk),
        .rst_n    (hresetn),
        .clr      (uv_s),
        .scl      (scl_s),
        .sda      (sda_s),
        .addr_sel (asel_s),
        .sda_oe   (sda_oe),
        .rd_data  (i2c_rd),
        .rd_idx   (i2c_ridx),
        .wr       (i2c_wr),
        .widx     (i2c_widx),
        .wdata    (i2c_wd)
    );

    // Read mux shared by both masters; write-only index reads zero
    // lock readable
    function automatic logic [7:0] rd_reg(input llcc_pkg::llcc_core_t s, input logic [3:0] i);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            `LLCC_IDX_CTRL: v = s.ctrl;
            `LLCC_IDX_LOOP: v = s.loop_ctl;
            `LLCC_IDX_FBL:  v = s.fbl;
            `LLCC_IDX_FBH:  v = {4'h0, s.fbh};
            `LLCC_IDX_ISTS: v = {5'h00, s.ists};
            `LLCC_IDX_IMSK: v = {5'h00, s.imsk};
            `LLCC_IDX_SCR6: v = s.scr6;
            `LLCC_IDX_SCR7: v = s.scr7;
            `LLCC_IDX_STAT: v = {4'h0, s.coast_d, s.dn, s.up, s.locked};
            `LLCC_IDX_ERR:  v = s.last_err;
            `LLCC_IDX_GOOD: v = {4'h0, s.good};
            default:        v = 8'h00;
        endcase
        return v;
    endfunction

    // Register write; read-only indices fall to default and change nothing
    // twelve word map
    function automatic llcc_pkg::llcc_core_t wr_reg(input llcc_pkg::llcc_core_t s, input logic [3:0] i,
                                                    input logic [7:0] d);
        llcc_pkg::llcc_core_t r;
        r = s;
        unique case (i)
            `LLCC_IDX_CTRL: r.ctrl     = d & `LLCC_CTRL_MASK;
            `LLCC_IDX_LOOP: r.loop_ctl = d;
            `LLCC_IDX_FBL:  r.fbl      = d;
            `LLCC_IDX_FBH:  r.fbh      = d[3:0];
            `LLCC_IDX_ISTS: r.ists     = s.ists & ~d[2:0];
            `LLCC_IDX_IMSK: r.imsk     = d[2:0];
            `LLCC_IDX_SCR6: r.scr6     = d;
            `LLCC_IDX_SCR7: r.scr7     = d;
            `LLCC_IDX_CMD:
                if (d[0])
                begin
                    r.locked = 1'b0;
                    r.good   = 4'h0;
                end
            default: r = s;
        endcase
        return r;
    endfunction

    // ********************************
    // Loop control
    // ********************************
    logic [3:0]  half;
    logic        pix_en, ref_e, fb_int_e, fb_e, coast;
    logic [12:0] ratio;
    logic        a_go;
    // Post divider of 2, 4, 8 or 16 sets half periods of 1, 2, 4 or 8
    // post divider output clock
    assign half   = 4'h1 << st.loop_ctl[5:4];
    assign pix_en = (st.divc == half - 4'h1) & ~st.pclk;
    assign ratio  = {1'b0, st.fbh, st.fbl} + `LLCC_FB_OFFS;
    assign fb_int_e = pix_en & (st.fbc >= ratio - 13'h0001);
    assign ref_e  = st.ctrl[`LLCC_B_HPOL] ? (st.ph & ~hs_s) : (~st.ph & hs_s);
    assign fb_e   = st.ctrl[`LLCC_B_FBSEL] ? (st.ctrl[`LLCC_B_FBPOL] ? (st.pe & ~ef_s) : (~st.pe & ef_s))
                                          : fb_int_e;
    assign coast  = ~st.ctrl[`LLCC_B_PUMPON] & (vs_s == st.ctrl[`LLCC_B_VPOL]);
    assign a_go   = hsel & htrans[1] & hready;

    // Next state of the whole block
    always_comb
    begin
        nx         = st;
        nx.ph      = hs_s;
        nx.pe      = ef_s;
        nx.coast_d = coast;
        // AHB address phase capture; word index is byte address over four
        if (hready)
        begin
            nx.awr  = a_go & hwrite;
            nx.aidx = haddr[5:2];
            nx.amap = (haddr[31:6] == 26'h0) & (haddr[5:2] <= `LLCC_IDX_GOOD);
        end
        // Pixel clock divider
        nx.divc = st.divc + 4'h1;
        if (st.divc >= half - 4'h1)
        begin
            nx.divc = 4'h0;
            nx.pclk = ~st.pclk;
        end
        if (pix_en)
        begin
            nx.fbc = fb_int_e ? 13'h0000 : st.fbc + 13'h0001;
            nx.hs  = hs_s;
            nx.vs  = vs_s;
        end
        // phase comparator, reset when both edges seen
        nx.up = st.up | ref_e;
        nx.dn = st.dn | fb_e;
        if (st.up | st.dn)
            nx.err = (st.err == 8'hFF) ? st.err : st.err + 8'h01;
        if (nx.up & nx.dn)
        begin
            nx.up       = 1'b0;
            nx.dn       = 1'b0;
            nx.err      = 8'h00;
            nx.last_err = st.err;
            if (st.err <= `LLCC_LOCK_TOL)
            begin
                nx.good = (st.good == `LLCC_LOCK_N) ? st.good : st.good + 4'h1;
                if (st.good == `LLCC_LOCK_N - 4'h1)
                    nx.locked = 1'b1;
            end
            else
            begin
                nx.good   = 4'h0;
                nx.locked = 1'b0;
            end
        end
        // Saturated error means no partner edge at all
        if (st.err == 8'hFF)
        begin
            nx.good   = 4'h0;
            nx.locked = 1'b0;
        end
        if (coast)
        begin
            nx.up  = 1'b0;
            nx.dn  = 1'b0;
            nx.err = 8'h00;
        end
        // Register writes: serial first, AHB data phase last
        if (i2c_wr)
            nx = wr_reg(nx, i2c_widx, i2c_wd);
        if (st.awr & st.amap)
            nx = wr_reg(nx, st.aidx, hwdata[7:0]);
        // Events after the clear so a same cycle event is kept
        nx.ists = nx.ists | {coast & ~st.coast_d, st.locked & ~nx.locked, ~st.locked & nx.locked};
        if (uv_s)
            nx = rst_val();
    end

    // Reset image: only the control register is nonzero
    function automatic llcc_pkg::llcc_core_t rst_val();
        llcc_pkg::llcc_core_t r;
        r      = '0;
        r.ctrl = `LLCC_CTRL_RST;
        return r;
    endfunction

    // State register; power-on comes in as hresetn
    // power-on reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= rst_val();
        else
            st <= nx;
    end

    // ********************************
    // Outputs
    // ********************************
    assign i2c_rd      = rd_reg(st, i2c_ridx);
    assign hrdata      = st.amap ? {24'h000000, rd_reg(st, st.aidx)} : 32'h00000000;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign pix_clk_out = st.pclk;
    assign hsync_out   = st.hs;
    assign vsync_out   = st.vs;
    assign lock_out    = st.locked & st.ctrl[`LLCC_B_ENLOCK];
    assign pump_up     = st.up;
    assign pump_dn     = st.dn;
    assign irq         = |(st.ists & st.imsk);

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence ctrl_wr_s;
        a_go && hwrite && haddr == 32'h00000000 && !uv_s ##1 !i2c_wr && !uv_s;
    endsequence
    sequence ro_wr_s;
        a_go && hwrite && haddr[31:2] == 30'h00000009 ##1 1'b1;
    endsequence
    ahb_okay_a:  assert property (hreadyout && !hresp) else $error("slave not ready or error");
    ctrl_wr_a:   assert property (ctrl_wr_s |=> st.ctrl == ($past(hwdata[7:0]) & `LLCC_CTRL_MASK))
                     else $error("control write lost");
    ro_keep_a:   assert property (ro_wr_s |=> !i2c_wr && !$past(i2c_wr) && !uv_s |->
                     st.fbl == $past(st.fbl) && st.ctrl == $past(st.ctrl))
                     else $error("read-only write changed registers");
    fb_wrap_a:   assert property (fb_int_e && !uv_s |=> st.fbc == 13'h0000)
                     else $error("feedback counter did not wrap");
    coast_off_a: assert property (coast_d_c() |-> !pump_up && !pump_dn)
                     else $error("pump active while coasting");
    retime_a:    assert property (pix_en && !uv_s |=> hsync_out == $past(hs_s) && vsync_out == $past(vs_s))
                     else $error("sync not retimed");
    lock_pin_a:  assert property (lock_out == (st.locked && st.ctrl[`LLCC_B_ENLOCK]))
                     else $error("lock pin mismatch");
    irq_lvl_a:   assert property (irq == |(st.ists & st.imsk)) else $error("interrupt level wrong");
    pfd_up_a:    assert property (ref_e && !fb_e && !st.dn && !coast && !uv_s |=> pump_up)
                     else $error("reference edge gave no pump up");
    pix_rate_a:  assert property (pix_en && !uv_s |=> !pix_en) else $error("pixel enable too fast");
    function automatic logic coast_d_c();
        return st.coast_d;
    endfunction
endmodule

// >>> design/llcc_map.svh
// Purpose: Offsets, field positions, reset values and counts of the line locked clock control.
// Assumes: Word index n sits at byte address 4*n on the register bus.
// Notes:   Definitions only.
// Behaviour
// - A 12-bit programmable counter divides the pixel clock, setting clocks per reference period.
// - The phase comparator drives pump up or down from the reference and feedback edge difference.
// - Feedback comes from the internal counter or the external feedback pin, by configuration.
// - The pixel clock comes from the oscillator post divider and itself clocks the feedback counter.
// - Sync outputs are the conditioned sync inputs retimed by flip-flops on the pixel clock.
// - In coast mode the vertical sync input suspends phase correction.
// - Lock status is readable over the serial interface and shown on the lock pin.
// - The serial slave works with the master clocking at 100 kHz or 400 kHz.
// - Twelve word addresses exist: one write-only, eight read/write and three read-only.
// - The slave answers address 0100110 with the select pin low and 0100111 with it high.
// - Internal state resets at power-on and on undervoltage without any reset pin of its own.
// - The feedback ratio is the programmed 12-bit value plus 8, from 8 to 4103.
// - Reference polarity 0 compares rising edges and 1 falling edges.
// - Pump enable 1 keeps correction always on; 0 lets vertical sync gate it.
// - With gating active, polarity 0 coasts while vertical sync is low, 1 while it is high.
`ifndef LLCC_MAP_SVH
`define LLCC_MAP_SVH
// ********************************
// Register indices
// ********************************
`define LLCC_IDX_CTRL  4'h0
`define LLCC_IDX_LOOP  4'h1
`define LLCC_IDX_FBL   4'h2
`define LLCC_IDX_FBH   4'h3
`define LLCC_IDX_ISTS  4'h4
`define LLCC_IDX_IMSK  4'h5
`define LLCC_IDX_SCR6  4'h6
`define LLCC_IDX_SCR7  4'h7
`define LLCC_IDX_CMD   4'h8
`define LLCC_IDX_STAT  4'h9
`define LLCC_IDX_ERR   4'hA
`define LLCC_IDX_GOOD  4'hB
// ********************************
// Fields, resets, counts
// ********************************
`define LLCC_B_PUMPON  0
`define LLCC_B_VPOL    1
`define LLCC_B_HPOL    2
`define LLCC_B_FBPOL   3
`define LLCC_B_FBSEL   4
`define LLCC_B_ENLOCK  6
`define LLCC_CTRL_RST  8'h41
`define LLCC_CTRL_MASK 8'h5F
`define LLCC_FB_OFFS   13'h0008
`define LLCC_LOCK_TOL  8'h04
`define LLCC_LOCK_N    4'h8
`define LLCC_SLV_ADDR  6'h13
`endif

// >>> design/llcc_pkg.sv
// Purpose: Types of the line locked clock control.
// Assumes: Constants live in llcc_map.svh.
// Notes:   State structs hold every flop of a module.
package llcc_pkg;
    typedef enum logic [5:0] {
        I2C_IDLE = 6'h01, I2C_ADDR = 6'h02, I2C_WRB = 6'h04,
        I2C_ACKS = 6'h08, I2C_RDB  = 6'h10, I2C_ACKM = 6'h20
    } llcc_i2c_st_t;
    typedef struct packed {
        llcc_i2c_st_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [3:0] ptr;
        logic       rw, got_ptr, ack, nack, scl_d, sda_d, wr;
        logic [7:0] wdata;
        logic [3:0] widx;
    } llcc_i2c_t;
    typedef struct packed {
        logic [3:0]  aidx;
        logic        awr, amap;
        logic [7:0]  ctrl, loop_ctl, fbl, scr6, scr7;
        logic [3:0]  fbh;
        logic [2:0]  ists, imsk;
        logic [3:0]  divc;
        logic        pclk;
        logic [12:0] fbc;
        logic        ph, pe, up, dn, locked, coast_d, hs, vs;
        logic [7:0]  err, last_err;
        logic [3:0]  good;
    } llcc_core_t;
endpackage

// >>> design/llcc_sync2.sv
// Purpose: Two flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes:   First stage feeds only the second.
`timescale 1ns/100ps
module llcc_sync2 #(parameter int W = 7)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    // Two stages per bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// >>> design/llcc_i2c.sv
// Purpose: Two-wire serial register slave.
// Assumes: scl and sda are already synchronised to clk.
// Notes:   Pointer write first, then data bytes with auto increment.
`timescale 1ns/100ps
`include "llcc_map.svh"
module llcc_i2c
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clr,
    // Bus lines, synchronised
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       addr_sel,
    output logic            sda_oe,
    // Register side
    input  wire logic [7:0] rd_data,
    output logic [3:0]      rd_idx,
    output logic            wr,
    output logic [3:0]      widx,
    output logic [7:0]      wdata
);
    llcc_pkg::llcc_i2c_t s_reg, s_next;
    logic rise, fall, start, stop;
    assign rise   = scl & ~s_reg.scl_d;
    assign fall   = ~scl & s_reg.scl_d;
    assign start  = scl & s_reg.scl_d & s_reg.sda_d & ~sda;
    assign stop   = scl & s_reg.scl_d & ~s_reg.sda_d & sda;
    assign rd_idx = s_reg.ptr;
    assign wr     = s_reg.wr;
    assign widx   = s_reg.widx;
    assign wdata  = s_reg.wdata;
    // Open drain: drive low for ack or a zero data bit
    assign sda_oe = s_reg.ack | ((s_reg.st == llcc_pkg::I2C_RDB) & ~s_reg.sh[7]);
    // Byte engine; edges are seen at 100 MHz so both bus rates are sampled many times per bit
    // rate independent sampling
    always_comb
    begin
        s_next       = s_reg;
        s_next.scl_d = scl;
        s_next.sda_d = sda;
        s_next.wr    = 1'b0;
        if (rise && s_reg.st != llcc_pkg::I2C_IDLE)
        begin
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.st != llcc_pkg::I2C_RDB)
                s_next.sh = {s_reg.sh[6:0], sda};
            if (s_reg.st == llcc_pkg::I2C_ACKM)
                s_next.nack = sda;
        end
        if (fall)
        begin
            unique case (s_reg.st)
                llcc_pkg::I2C_IDLE: ;
                llcc_pkg::I2C_ADDR, llcc_pkg::I2C_WRB:
                    if (s_reg.cnt == 4'h8)
                    begin
                        s_next.st = llcc_pkg::I2C_ACKS;
                        s_next.ack = 1'b1;
                        if (s_reg.st == llcc_pkg::I2C_ADDR)
                        begin
                            if (s_reg.sh[7:1] != {`LLCC_SLV_ADDR, addr_sel})
                            begin
                                s_next.st  = llcc_pkg::I2C_IDLE;
                                s_next.ack = 1'b0;
                            end
                            s_next.rw = s_reg.sh[0];
                        end
                        else if (!s_reg.got_ptr)
                        begin
                            s_next.ptr     = s_reg.sh[3:0];
                            s_next.got_ptr = 1'b1;
                        end
                        else
                        begin
                            s_next.wr    = 1'b1;
                            s_next.widx  = s_reg.ptr;
                            s_next.wdata = s_reg.sh;
                            s_next.ptr   = s_reg.ptr + 4'h1;
                        end
                    end
                llcc_pkg::I2C_ACKS, llcc_pkg::I2C_ACKM:
                begin
                    s_next.ack = 1'b0;
                    s_next.cnt = 4'h0;
                    s_next.st  = s_reg.rw ? llcc_pkg::I2C_RDB : llcc_pkg::I2C_WRB;
                    s_next.sh  = rd_data;
                    if (s_reg.st == llcc_pkg::I2C_ACKM && s_reg.nack)
                        s_next.st = llcc_pkg::I2C_IDLE;
                end
                llcc_pkg::I2C_RDB:
                    if (s_reg.cnt == 4'h8)
                    begin
                        s_next.st  = llcc_pkg::I2C_ACKM;
                        s_next.ptr = s_reg.ptr + 4'h1;
                    end
                    else
                        s_next.sh = {s_reg.sh[6:0], 1'b0};
            endcase
        end
        if (start)
        begin
            s_next.st      = llcc_pkg::I2C_ADDR;
            s_next.cnt     = 4'h0;
            s_next.got_ptr = 1'b0;
            s_next.ack     = 1'b0;
        end
        if (stop || clr)
        begin
            s_next.st  = llcc_pkg::I2C_IDLE;
            s_next.ack = 1'b0;
        end
    end
    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg     <= '0;
            s_reg.st  <= llcc_pkg::I2C_IDLE;
        end
        else
            s_reg <= s_next;
    end
endmodule

// >>> sim/llcc_i2c_master.sv
// Purpose: Two-wire bus master model for the serial slave.
// Assumes: SDA has a pull-up; sda_line is the resolved wire.
// Notes:   Quarter bit of 63 hclk, close to 400 kHz.
`timescale 1ns/100ps
module llcc_i2c_master
(
    // Clock and resolved wire
    input  wire logic clk,
    input  wire logic sda_line,
    // Driven levels, high means released
    output logic      scl,
    output logic      sda
);
    // Idle bus is released high
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic q;
        repeat (63) @(posedge clk);
    endtask
    // START: data falls while the clock is high
    task automatic start;
        sda <= 1'b0;
        q();
        scl <= 1'b0;
        q();
    endtask
    // Nine bits; the last one is released so the slave can acknowledge
    task automatic put(input logic [8:0] b, output logic ack);
        for (int i = 8; i >= 0; i--)
        begin
            sda <= b[i];
            q();
            scl <= 1'b1;
            q();
            if (i == 0)
                ack = ~sda_line;
            q();
            scl <= 1'b0;
            q();
        end
    endtask
    // STOP: data rises while the clock is high
    task automatic stop;
        sda <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b1;
        q();
    endtask
endmodule

// >>> sim/line_locked_clock_control_bench.sv
// Purpose: Self-checking bench of the line locked clock control.
// Assumes: Zero wait AHB slave; pull-up on SDA.
// Notes:   Read data is taken at the edge that ends the data phase.
`timescale 1ns/100ps
module line_locked_clock_control_bench;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, ack;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hsync_in, vsync_in, supply_low, scl_in, sda_m, slave_addr_select;
    logic        sda_oe, pix_clk_out, hsync_out, lock_out, irq, p;
    logic [7:0]  rd;
    int          mismatches, tests_run, n;
    // Open drain wire: pulled up unless the master or the slave pulls it down
    wire         sda_line = sda_m & ~sda_oe;
    assign hready = hreadyout;
    llcc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hrdata, .hreadyout, .hresp(), .hsync_in, .vsync_in, .ext_feedback_in(1'b0), .supply_low,
        .scl_in, .sda_in(sda_line), .slave_addr_select, .sda_out(), .sda_oe, .pix_clk_out,
        .hsync_out, .vsync_out(), .lock_out, .pump_up(), .pump_dn(), .irq);
    llcc_i2c_master master (.clk(hclk), .sda_line, .scl(scl_in), .sda(sda_m));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    // One AHB single transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {26'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        // Sampled before the edge's register update, so the data phase value is seen
        do
            @(posedge hclk);
        while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask
    task automatic rdchk(input logic [3:0] idx, input logic [7:0] want);
        bus(1'b0, idx, 8'h00);
        check(rd, want);
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Clock, 10 ns period
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // A hang is cut short well past the expected run
    initial
    begin
        #400000;
        mismatches++;
        wrap_up();
    end
    // ********************************
    // Tests
    // ********************************
    initial
    begin
        {hresetn, hsel, hwrite, hsync_in, vsync_in, supply_low, slave_addr_select} = 7'h00;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'h2;
        mismatches = 0;
        tests_run = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(4'h0, 8'h41);
        bus(1'b1, 4'h6, 8'hA5);
        rdchk(4'h6, 8'hA5);
        bus(1'b1, 4'h3, 8'hFF);
        rdchk(4'h3, 8'h0F);
        bus(1'b1, 4'hB, 8'h5A);
        rdchk(4'hB, 8'h00);
        rdchk(4'hC, 8'h00);
        // Post divider sets pixel period 2, 4, 8, 16
        for (int d = 0; d < 4; d++)
        begin
            bus(1'b1, 4'h1, {2'h0, 2'(d), 4'h0});
            repeat (40) @(negedge hclk);
            p = pix_clk_out;
            n = 0;
            repeat (64)
            begin
                @(negedge hclk);
                n = n + int'(pix_clk_out & ~p);
                p = pix_clk_out;
            end
            check(8'(n), 8'(32 >> d));
        end
        // Sync passes two sync flops, then the pixel retiming flop
        @(posedge hclk);
        hsync_in <= 1'b1;
        repeat (2) @(negedge hclk);
        check({7'h0, hsync_out}, 8'h00);
        repeat (40) @(negedge hclk);
        check({7'h0, hsync_out}, 8'h01);
        // Coast per polarity and pump enable; irq masked on the first case
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, 4'h5, {5'h0, k != 0, 2'h0});
            bus(1'b1, 4'h0, 8'h40 | {6'h0, k != 0, k == 3});
            vsync_in <= k[0];
            repeat (8) @(posedge hclk);
            bus(1'b0, 4'h9, 8'h00);
            check(rd & 8'h08, {4'h0, k < 2, 3'h0});
            bus(1'b0, 4'h4, 8'h00);
            check(rd & 8'h04, {5'h0, k < 2, 2'h0});
            check({7'h0, irq}, {7'h0, k == 1});
            bus(1'b1, 4'h4, 8'h04);
            @(negedge hclk);
            check({7'h0, irq}, 8'h00);
        end
        bus(1'b0, 4'h9, 8'h00);
        check({7'h0, lock_out}, rd & 8'h01);
        // Serial: wrong address refused, right one writes scratch 7
        slave_addr_select <= 1'b1;
        repeat (4) @(posedge hclk);
        master.start();
        master.put({7'h26, 1'b0, 1'b1}, ack);
        check({7'h0, ack}, 8'h00);
        master.stop();
        master.start();
        master.put({7'h27, 1'b0, 1'b1}, ack);
        check({7'h0, ack}, 8'h01);
        master.put({8'h07, 1'b1}, ack);
        master.put({8'h3C, 1'b1}, ack);
        master.stop();
        rdchk(4'h7, 8'h3C);
        // Undervoltage brings back the reset image
        @(posedge hclk);
        supply_low <= 1'b1;
        repeat (6) @(posedge hclk);
        supply_low <= 1'b0;
        repeat (6) @(posedge hclk);
        rdchk(4'h0, 8'h41);
        rdchk(4'h7, 8'h00);
        wrap_up();
    end
endmodule
